// file: sirpe_pkg.sv
package sirpe_pkg;

  // core clock and pulse timing
  localparam int unsigned CORE_PERIOD_NS   = 25;
  localparam int unsigned FIXED_PULSE_NS   = 1600;
  localparam int unsigned FIXED_PULSE_CYC  =
    (FIXED_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W      = 7;

  // codec clock counts, in ticks of the 16x clock
  localparam int unsigned BIT_TICKS        = 16;
  localparam int unsigned ENC_DELAY_TICKS  = 7;
  localparam int unsigned SHORT_PULSE_TICKS = 3;
  localparam logic [3:0]  TICK_LAST        = 4'(BIT_TICKS - 1);
  localparam logic [3:0]  TICK_PULSE_ON    = 4'(ENC_DELAY_TICKS - 1);
  localparam logic [3:0]  TICK_PULSE_OFF   = 4'(ENC_DELAY_TICKS + SHORT_PULSE_TICKS - 1);

  // receive event buffer
  localparam int unsigned RX_BUF_DEPTH     = 2;
  localparam int unsigned RX_EVT_W         = 1;

  typedef enum logic [1:0] {
    SIRPE_ENC_IDLE  = 2'b00,
    SIRPE_ENC_WAIT  = 2'b01,
    SIRPE_ENC_PULSE = 2'b11,
    SIRPE_ENC_REST  = 2'b10
  } sirpe_enc_state_t;

  typedef enum logic {
    SIRPE_DEC_IDLE = 1'b0,
    SIRPE_DEC_LOW  = 1'b1
  } sirpe_dec_state_t;

  // pin levels crossing into the core clock together
  typedef struct packed {
    logic codec_clk;
    logic tx;
    logic ir;
    logic width_sel;
    logic sleep;
    logic reset_n;
  } sirpe_pins_t;

  localparam sirpe_pins_t PINS_IDLE = '{codec_clk: 1'b0, tx: 1'b1, ir: 1'b1,
                                        width_sel: 1'b1, sleep: 1'b0, reset_n: 1'b0};

  typedef struct packed {
    logic [RX_EVT_W-1:0] bit_val;
  } sirpe_rx_evt_t;

endpackage

// file: sirpe_codec.sv
// What this block does
// - each space bit on the transmit input yields exactly one emitter pulse.
// - the pulse starts seven codec ticks after the falling edge of the transmit input.
// - width select high gives a 1.6 us pulse, low gives three codec ticks.
// - an unconnected width select is not pulled high inside the block; it needs a pad pull-up to give 1.6 us pulses.
// - back-to-back space bits give one pulse per bit, sixteen ticks apart.
// - a mark bit leaves the emitter off for that bit.
// - each falling edge on the infrared receive pulse is one incoming pulse.
// - each incoming pulse becomes a sixteen-tick low on the UART receive output.
// - pulses one bit apart give a continuous low, one bit per pulse.
// - the active-low codec reset returns encoder and decoder to idle.
// - sleep high puts the block in a low-current state, low keeps it active.
`timescale 1ns/10ps
`default_nettype none
module sirpe_codec
  import sirpe_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic codec_clk_16x,
  input  wire logic uart_tx_in,
  input  wire logic ir_rx_pulse,
  input  wire logic pulse_width_select,
  input  wire logic sleep_in,
  input  wire logic codec_reset_n,
  output logic      ir_emitter_out,
  output logic      uart_rx_out,
  output logic      low_power_out
);

  sirpe_pins_t pins_raw;
  sirpe_pins_t meta_q;
  sirpe_pins_t sync_q;
  logic        clk_prev_q;
  logic        tx_prev_q;
  logic        ir_prev_q;
  logic        tick;
  logic        tx_fall;
  logic        ir_fall;
  logic        soft_rst;

  // width select needs a pad pull-up so a floating pin reads high
  assign pins_raw = '{codec_clk: codec_clk_16x, tx: uart_tx_in, ir: ir_rx_pulse,
                      width_sel: pulse_width_select, sleep: sleep_in,
                      reset_n: codec_reset_n};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q     <= PINS_IDLE;
      sync_q     <= PINS_IDLE;
      clk_prev_q <= 1'b0;
      tx_prev_q  <= 1'b1;
      ir_prev_q  <= 1'b1;
    end else begin
      meta_q     <= pins_raw;
      sync_q     <= meta_q;
      clk_prev_q <= sync_q.codec_clk;
      tx_prev_q  <= sync_q.tx;
      ir_prev_q  <= sync_q.ir;
    end
  end

  // codec clock is sampled, so it must stay well below half the core rate
  assign tick     = sync_q.codec_clk & ~clk_prev_q;
  assign tx_fall  = tx_prev_q & ~sync_q.tx;
  assign ir_fall  = ir_prev_q & ~sync_q.ir;
  assign soft_rst = ~sync_q.reset_n | sync_q.sleep;

  // ---------------- encoder ----------------
  sirpe_enc_state_t       enc_state_q, enc_state_d;
  logic [3:0]             enc_cnt_q, enc_cnt_d;
  logic [PULSE_CNT_W-1:0] pulse_cnt_q, pulse_cnt_d;
  logic                   mode_q, mode_d;
  logic                   emit_q, emit_d;

  always_comb begin
    enc_state_d = enc_state_q;
    enc_cnt_d   = enc_cnt_q;
    pulse_cnt_d = pulse_cnt_q;
    mode_d      = mode_q;
    if (tick && enc_state_q != SIRPE_ENC_IDLE) begin
      enc_cnt_d = enc_cnt_q + 4'h1;
    end
    case (enc_state_q)
      SIRPE_ENC_IDLE: begin
        if (tx_fall) begin
          enc_state_d = SIRPE_ENC_WAIT;
          enc_cnt_d   = 4'h0;
        end
      end
      SIRPE_ENC_WAIT: begin
        if (tick && enc_cnt_q == TICK_PULSE_ON) begin
          enc_state_d = SIRPE_ENC_PULSE;
          pulse_cnt_d = '0;
          mode_d      = sync_q.width_sel;
        end
      end
      SIRPE_ENC_PULSE: begin
        pulse_cnt_d = pulse_cnt_q + 7'h01;
        if (mode_q) begin
          if (pulse_cnt_q == PULSE_CNT_W'(FIXED_PULSE_CYC - 1)) begin
            enc_state_d = SIRPE_ENC_REST;
          end
        end else if (tick && enc_cnt_q == TICK_PULSE_OFF) begin
          enc_state_d = SIRPE_ENC_REST;
        end
      end
      SIRPE_ENC_REST: begin
        // line sampled at bit end: another space starts the next pulse
        if (tick && enc_cnt_q == TICK_LAST) begin
          enc_state_d = sync_q.tx ? SIRPE_ENC_IDLE : SIRPE_ENC_WAIT;
        end
      end
      default: enc_state_d = SIRPE_ENC_IDLE;
    endcase
    if (soft_rst) begin
      enc_state_d = SIRPE_ENC_IDLE;
      enc_cnt_d   = 4'h0;
    end
    emit_d = (enc_state_d == SIRPE_ENC_PULSE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enc_state_q <= SIRPE_ENC_IDLE;
      enc_cnt_q   <= 4'h0;
      pulse_cnt_q <= '0;
      mode_q      <= 1'b1;
      emit_q      <= 1'b0;
    end else begin
      enc_state_q <= enc_state_d;
      enc_cnt_q   <= enc_cnt_d;
      pulse_cnt_q <= pulse_cnt_d;
      mode_q      <= mode_d;
      emit_q      <= emit_d;
    end
  end

  // ---------------- receive event buffer ----------------
  sirpe_rx_evt_t buf_mem_q [RX_BUF_DEPTH];
  sirpe_rx_evt_t buf_mem_d [RX_BUF_DEPTH];
  logic          wr_ptr_q, wr_ptr_d;
  logic          rd_ptr_q, rd_ptr_d;
  logic [1:0]    buf_cnt_q, buf_cnt_d;
  logic          pend_q, pend_d;
  logic          in_ready;
  logic          out_valid;
  logic          pop;
  logic          push;

  assign in_ready  = (buf_cnt_q != 2'(RX_BUF_DEPTH));
  assign out_valid = (buf_cnt_q != 2'h0);
  assign push      = pend_q & in_ready;

  always_comb begin
    buf_mem_d = buf_mem_q;
    wr_ptr_d  = wr_ptr_q;
    rd_ptr_d  = rd_ptr_q;
    buf_cnt_d = buf_cnt_q;
    // a new edge wins over the accept of the previous one
    pend_d    = ir_fall | (pend_q & ~in_ready);
    if (push) begin
      buf_mem_d[wr_ptr_q] = '{bit_val: 1'b0};
      wr_ptr_d            = ~wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
    buf_cnt_d = buf_cnt_q + {1'b0, push} - {1'b0, pop};
    if (soft_rst) begin
      wr_ptr_d  = 1'b0;
      rd_ptr_d  = 1'b0;
      buf_cnt_d = 2'h0;
      pend_d    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_mem_q <= '{default: '0};
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
      pend_q    <= 1'b0;
    end else begin
      buf_mem_q <= buf_mem_d;
      wr_ptr_q  <= wr_ptr_d;
      rd_ptr_q  <= rd_ptr_d;
      buf_cnt_q <= buf_cnt_d;
      pend_q    <= pend_d;
    end
  end

  // ---------------- decoder stretcher ----------------
  sirpe_dec_state_t dec_state_q, dec_state_d;
  logic [3:0]       dec_cnt_q, dec_cnt_d;
  logic             rx_q, rx_d;
  logic             low_pwr_q;

  always_comb begin
    dec_state_d = dec_state_q;
    dec_cnt_d   = dec_cnt_q;
    pop         = 1'b0;
    case (dec_state_q)
      SIRPE_DEC_IDLE: begin
        // start only on a tick, so a pulse one bit later lands on the 16th tick
        if (out_valid && tick) begin
          pop         = 1'b1;
          dec_state_d = SIRPE_DEC_LOW;
          dec_cnt_d   = 4'h0;
        end
      end
      SIRPE_DEC_LOW: begin
        if (tick) begin
          dec_cnt_d = dec_cnt_q + 4'h1;
          if (dec_cnt_q == TICK_LAST) begin
            // a queued pulse keeps the line low without a glitch
            pop         = out_valid;
            dec_state_d = out_valid ? SIRPE_DEC_LOW : SIRPE_DEC_IDLE;
          end
        end
      end
      default: dec_state_d = SIRPE_DEC_IDLE;
    endcase
    if (soft_rst) begin
      dec_state_d = SIRPE_DEC_IDLE;
      dec_cnt_d   = 4'h0;
      pop         = 1'b0;
    end
    rx_d = ~(dec_state_d == SIRPE_DEC_LOW) |
           buf_mem_q[rd_ptr_q].bit_val[0] & ~pop;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec_state_q <= SIRPE_DEC_IDLE;
      dec_cnt_q   <= 4'h0;
      rx_q        <= 1'b1;
      low_pwr_q   <= 1'b0;
    end else begin
      dec_state_q <= dec_state_d;
      dec_cnt_q   <= dec_cnt_d;
      rx_q        <= rx_d;
      low_pwr_q   <= sync_q.sleep;
    end
  end

  assign ir_emitter_out = emit_q;
  assign uart_rx_out    = rx_q;
  assign low_power_out  = low_pwr_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_emit_reset_off: assert property (soft_rst |=> !ir_emitter_out)
    else $error("emitter on after codec reset or sleep");
  a_rx_reset_high: assert property (soft_rst |=> uart_rx_out)
    else $error("receive output low after codec reset or sleep");
  a_pulse_delay: assert property ($rose(ir_emitter_out) |-> enc_cnt_q == 4'h7)
    else $error("emitter pulse did not start at tick seven");
  a_short_width: assert property ($fell(ir_emitter_out) && !mode_q && !$past(soft_rst)
                                  |-> enc_cnt_q == 4'ha)
    else $error("short pulse not three ticks");
  a_fixed_width: assert property ($rose(ir_emitter_out) && mode_q
                                  |-> ir_emitter_out[*8] ##0 pulse_cnt_q == 7'h07)
    else $error("fixed pulse ended early");
  a_fixed_end: assert property ($fell(ir_emitter_out) && mode_q && !$past(soft_rst)
                                |-> $past(pulse_cnt_q) == 7'(FIXED_PULSE_CYC - 1))
    else $error("fixed pulse not 1.6 us");
  a_mark_quiet: assert property (enc_state_q == SIRPE_ENC_IDLE && sync_q.tx
                                 |=> !ir_emitter_out)
    else $error("pulse during mark");
  a_stretch_end: assert property ($rose(uart_rx_out) && !$past(soft_rst)
                                  |-> $past(dec_cnt_q) == TICK_LAST)
    else $error("stretch shorter than a bit");
  a_back_to_back: assert property (dec_state_q == SIRPE_DEC_LOW && tick && out_valid &&
                                   dec_cnt_q == TICK_LAST && !soft_rst
                                   |=> !uart_rx_out ##1 !uart_rx_out)
    else $error("gap between consecutive stretched bits");
  a_sleep_state: assert property (sync_q.sleep |=> low_power_out ##0 !ir_emitter_out)
    else $error("sleep not reflected");

endmodule
`default_nettype wire

// file: sirpe_uart_model.sv
`timescale 1ns/10ps
`default_nettype none
module sirpe_uart_model (
  input  wire logic core_clk,
  input  wire logic uart_rx_out,
  output logic      codec_clk_16x,
  output logic      uart_tx_in
);
  // divider free runs: the uart baud clock never stops
  logic [6:0] div_q = 7'h00;

  always @(negedge core_clk) begin
    div_q <= div_q + 7'h01;
  end
  // 8 core cycles per tick, 16 ticks per bit
  assign codec_clk_16x = div_q[2];

  initial uart_tx_in = 1'b1;

  // bits go out lsb first, each edge on a rising codec clock edge as a uart shifts
  task automatic send(input logic [7:0] bits, input int n);
    for (int i = 0; i <= n; i++) begin
      for (int k = 0; k < 128; k++) begin
        @(negedge core_clk);
        if (div_q == 7'h03) break;
      end
      uart_tx_in = (i < n) ? bits[i] : 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sirpe_pkg::*;
;
  localparam int TK = 8;
  localparam int BC = BIT_TICKS * TK;
  logic core_clk = 1'b0, rst = 1'b1, ir_rx_pulse = 1'b1, pulse_width_select = 1'b1;
  logic sleep_in = 1'b0, codec_reset_n = 1'b0, em_p = 1'b0, rx_p = 1'b1;
  logic tx_p = 1'b1, ir_p = 1'b1;
  wire logic codec_clk_16x, uart_tx_in, ir_emitter_out, uart_rx_out, low_power_out;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  int em_r[$], em_f[$], rx_f[$], rx_r[$], tx_f[$], ir_f[$];

  always #12.5 core_clk = ~core_clk;

  sirpe_codec i_sirpe_codec (.core_clk(core_clk), .rst(rst), .codec_clk_16x(codec_clk_16x),
    .uart_tx_in(uart_tx_in), .ir_rx_pulse(ir_rx_pulse), .pulse_width_select(pulse_width_select),
    .sleep_in(sleep_in), .codec_reset_n(codec_reset_n), .ir_emitter_out(ir_emitter_out),
    .uart_rx_out(uart_rx_out), .low_power_out(low_power_out));
  sirpe_uart_model i_sirpe_uart_model (.core_clk(core_clk), .uart_rx_out(uart_rx_out),
    .codec_clk_16x(codec_clk_16x), .uart_tx_in(uart_tx_in));

  // edge log in core cycles; all signals seen with the same lag
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ir_emitter_out === 1'b1 && em_p !== 1'b1) em_r.push_back(cyc);
    if (ir_emitter_out === 1'b0 && em_p === 1'b1) em_f.push_back(cyc);
    if (uart_rx_out === 1'b0 && rx_p !== 1'b0) rx_f.push_back(cyc);
    if (uart_rx_out === 1'b1 && rx_p === 1'b0) rx_r.push_back(cyc);
    if (uart_tx_in === 1'b0 && tx_p === 1'b1) tx_f.push_back(cyc);
    if (ir_rx_pulse === 1'b0 && ir_p === 1'b1) ir_f.push_back(cyc);
    em_p <= ir_emitter_out;
    rx_p <= uart_rx_out;
    tx_p <= uart_tx_in;
    ir_p <= ir_rx_pulse;
  end

  task automatic conclude;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string m);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0d", $time, m, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic clear;
    em_r.delete(); em_f.delete(); rx_f.delete(); rx_r.delete(); tx_f.delete(); ir_f.delete();
  endtask

  // optical pulse of 3 ticks, as a far transmitter sends it
  task automatic ir_pulse;
    ir_rx_pulse = 1'b0;
    idle(3 * TK);
    ir_rx_pulse = 1'b1;
  endtask

  task automatic t_reset;
    chk_bit(ir_emitter_out, 1'b0, "emitter in reset");
    chk_bit(uart_rx_out, 1'b1, "rx idle in reset");
    clear();
    i_sirpe_uart_model.send(8'h00, 1);
    idle(BC);
    chk_rng(em_r.size(), 0, 0, "pulse under codec reset");
    codec_reset_n = 1'b1;
    idle(8);
    $display("t_reset done");
  endtask

  // space mark space space mark: three pulses, none for marks
  task automatic t_tx(input logic sel, input int w);
    pulse_width_select = sel;
    idle(8);
    clear();
    i_sirpe_uart_model.send(8'h12, 5);
    idle(2 * BC);
    chk_rng(em_r.size(), 3, 3, "pulse count");
    if (em_r.size() == 3 && tx_f.size() == 2) begin
      chk_rng(em_r[0] - tx_f[0], 7 * TK - 3, 7 * TK + 8, "pulse delay");
      chk_rng(em_r[1] - tx_f[1], 7 * TK - 3, 7 * TK + 8, "pulse delay 2");
      chk_rng(em_r[2] - em_r[1], BC, BC, "space spacing");
      foreach (em_r[i]) chk_rng(em_f[i] - em_r[i], w, w, "pulse width");
    end
    $display("t_tx done");
  endtask

  task automatic t_rx;
    clear();
    ir_pulse();
    idle(2 * BC);
    chk_bit(uart_rx_out, 1'b1, "rx back to mark");
    chk_rng(rx_f.size(), 1, 1, "one stretch");
    if (rx_f.size() == 1 && rx_r.size() == 1) begin
      chk_rng(rx_f[0] - ir_f[0], 5, 5 + TK - 1, "stretch start");
      chk_rng(rx_r[0] - rx_f[0], BC - TK, BC + 2, "stretch length");
    end
    clear();
    ir_pulse();
    idle(BC - 3 * TK);
    ir_pulse();
    idle(3 * BC);
    chk_rng(rx_f.size(), 1, 1, "continuous low");
    if (rx_f.size() == 1 && rx_r.size() == 1)
      chk_rng(rx_r[0] - rx_f[0], 2 * BC - TK, 2 * BC + 2, "two bit low");
    $display("t_rx done");
  endtask

  task automatic t_sleep;
    sleep_in = 1'b1;
    idle(8);
    chk_bit(low_power_out, 1'b1, "sleep flag");
    clear();
    i_sirpe_uart_model.send(8'h00, 1);
    ir_pulse();
    idle(2 * BC);
    chk_rng(em_r.size() + rx_f.size(), 0, 0, "activity in sleep");
    sleep_in = 1'b0;
    idle(8);
    chk_bit(low_power_out, 1'b0, "awake flag");
    $display("t_sleep done");
  endtask

  // codec reset in mid stretch must end it at once
  task automatic t_midreset;
    ir_pulse();
    idle(40);
    chk_bit(uart_rx_out, 1'b0, "stretch running");
    codec_reset_n = 1'b0;
    idle(8);
    chk_bit(uart_rx_out, 1'b1, "reset ends stretch");
    codec_reset_n = 1'b1;
    idle(8);
    $display("t_midreset done");
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_tx(1'b0, SHORT_PULSE_TICKS * TK);
    t_tx(1'b1, FIXED_PULSE_CYC);
    t_rx();
    t_sleep();
    t_midreset();
    conclude();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    $display("[FAIL] %0t run limit reached", $time);
    conclude();
  end
endmodule
`default_nettype wire
